// *** hw/sdf_pkg.sv ***
// Package for the stairway dual-function lamp switch.
// Assumes a 50 MHz pclk; the tick divider count derives from it, the other timing counts from the tick.
package sdf_pkg;

  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned HOLD_MIN = 6;
  localparam int unsigned HOLD_TICKS = HOLD_MIN * 60 * 1000 / TICK_MS;
  localparam int unsigned LONG_MS = 1000;
  localparam int unsigned LONG_TICKS = LONG_MS / TICK_MS;
  localparam int unsigned WARN_MS = 3000;
  localparam int unsigned WARN_TICKS = WARN_MS / TICK_MS;
  localparam int unsigned FLICK_MS = 200;
  localparam int unsigned FLICK_TICKS = FLICK_MS / TICK_MS;
  localparam int unsigned TW = 24;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOLD = 8'h04;
  localparam logic [7:0] ADDR_LONG = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_WARN_BIT = 2;
  localparam int unsigned CTRL_COFF_EN_BIT = 3;
  localparam int unsigned CTRL_CON_EN_BIT = 4;

  typedef enum logic [1:0] {
    SDF_MODE_PULSE = 2'h0,
    SDF_MODE_STAIR = 2'h1,
    SDF_MODE_DUAL = 2'h2
  } sdf_mode_t;

  typedef enum logic [3:0] {
    SDF_OFF = 4'h1,
    SDF_TIMED = 4'h2,
    SDF_WARN = 4'h4,
    SDF_LATCH = 4'h8
  } sdf_state_t;

  typedef struct packed {
    logic con_en;
    logic coff_en;
    logic warn_en;
    sdf_mode_t mode;
  } sdf_ctrl_t;

  localparam logic [4:0] CTRL_RESET = 5'h02;

endpackage

// *** hw/sdf_sync.sv ***
// Three-flop input synchroniser with second/third agreement.
// Assumes the input is asynchronous to pclk.
module sdf_sync
  import sdf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Signal
  input wire logic din,
  output logic dout
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Change only accepted once both later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      dout <= s3_ff;
    end
  end

endmodule

// *** hw/sdf_switch.sv ***
// Stairway dual-function lamp switch with APB control registers.
// Assumes a momentary button and central inputs from pins; APB master on pclk.
// Hold and long-press registers count ticks of the divided time base, not clocks.
//////////////////////////////////////////////////////////////////////////////
module sdf_switch
  import sdf_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter logic [TW-1:0] HOLD_DEF = TW'(HOLD_TICKS),
  parameter logic [TW-1:0] LONG_DEF = TW'(LONG_TICKS)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic light_button_input,
  input wire logic central_off_input,
  input wire logic central_on_input,
  output logic lamp_output
);

  //////////////////////////////////////////////////////////////////////////////
  sdf_ctrl_t ctrl_ff;
  logic [TW-1:0] hold_ff;
  logic [TW-1:0] long_ff;
  logic [31:0] prdata_ff;
  logic slverr_ff;
  logic btn;
  logic coff;
  logic con;
  logic btn_d_ff;
  logic press;
  logic tick;
  logic [31:0] div_ff;
  logic [TW-1:0] tmr_ff;
  logic [TW-1:0] hold_cnt_ff;
  logic long_done_ff;
  logic flick_ff;
  logic [TW-1:0] flick_cnt_ff;
  logic lamp_ff;
  sdf_state_t state_ff;
  sdf_state_t nxt_state;
  logic wr;
  logic rd;
  logic warn_start;
  logic addr_hit;
  logic pulse_mode;
  logic dual_mode;
  logic expire;
  logic long_hit;
  logic nxt_lamp;

  // Every pin input is asynchronous, so each passes its own synchroniser
  sdf_sync u_btn (
    .pclk(pclk),
    .presetn(presetn),
    .din(light_button_input),
    .dout(btn)
  );

  sdf_sync u_coff (
    .pclk(pclk),
    .presetn(presetn),
    .din(central_off_input),
    .dout(coff)
  );

  sdf_sync u_con (
    .pclk(pclk),
    .presetn(presetn),
    .din(central_on_input),
    .dout(con)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB: zero wait states; unmapped addresses answer with pslverr
  assign pready = 1'b1;
  assign pslverr = slverr_ff & psel & penable;
  assign prdata = prdata_ff;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= sdf_ctrl_t'(CTRL_RESET);
    end else if (wr && paddr == ADDR_CTRL) begin
      ctrl_ff <= sdf_ctrl_t'(pwdata[4:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= HOLD_DEF;
    end else if (wr && paddr == ADDR_HOLD) begin
      hold_ff <= pwdata[TW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_ff <= LONG_DEF;
    end else if (wr && paddr == ADDR_LONG) begin
      long_ff <= pwdata[TW-1:0];
    end
  end

  // Full decode: any other offset, aligned or not, answers with an error
  always_comb begin
    addr_hit = 1'b0;
    unique case (paddr)
      ADDR_CTRL: addr_hit = 1'b1;
      ADDR_HOLD: addr_hit = 1'b1;
      ADDR_LONG: addr_hit = 1'b1;
      ADDR_STAT: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Read data captured in setup so it stands registered for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (rd) begin
      unique case (paddr)
        ADDR_CTRL: prdata_ff <= {27'h0, ctrl_ff};
        ADDR_HOLD: prdata_ff <= {8'h0, hold_ff};
        ADDR_LONG: prdata_ff <= {8'h0, long_ff};
        ADDR_STAT: prdata_ff <= {24'h0, state_ff, 2'h0, btn, lamp_output};
        default: prdata_ff <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_ff <= 1'b0;
    end else if (psel & ~penable) begin
      slverr_ff <= !addr_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time base
  // A coarse tick keeps the 24-bit hold counters good for many hours of light
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 32'h0;
    end else if (div_ff >= 32'(TICK_DIV - 1)) begin
      div_ff <= 32'h0;
    end else begin
      div_ff <= div_ff + 32'h1;
    end
  end
  assign tick = (div_ff == 32'(TICK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_d_ff <= 1'b0;
    end else begin
      btn_d_ff <= btn;
    end
  end
  assign press = btn & ~btn_d_ff;

  // Long-press measurement; held across the whole press
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_ff <= '0;
      long_done_ff <= 1'b0;
    end else if (!btn) begin
      hold_cnt_ff <= '0;
      long_done_ff <= 1'b0;
    end else if (tick && !long_done_ff) begin
      hold_cnt_ff <= hold_cnt_ff + TW'(1);
      long_done_ff <= (hold_cnt_ff + TW'(1) >= long_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lamp state machine
  assign warn_start = ctrl_ff.warn_en && tmr_ff <= TW'(WARN_TICKS);
  assign pulse_mode = (ctrl_ff.mode == SDF_MODE_PULSE);
  assign dual_mode = (ctrl_ff.mode == SDF_MODE_DUAL);
  // Expiry is taken on the tick that would bring the count to zero
  assign expire = tick && tmr_ff <= TW'(1);
  assign long_hit = dual_mode && btn && long_done_ff;

  // Pulse mode reuses the latched state as its plain on state

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SDF_OFF: begin
        if (press) begin
          nxt_state = pulse_mode ? SDF_LATCH : SDF_TIMED;
        end
      end
      SDF_TIMED: begin
        if (pulse_mode && press) begin
          nxt_state = SDF_OFF;
        end else if (long_hit) begin
          nxt_state = SDF_LATCH;
        end else if (warn_start) begin
          nxt_state = SDF_WARN;
        end else if (expire) begin
          nxt_state = SDF_OFF;
        end
      end
      SDF_WARN: begin
        if (press) begin
          nxt_state = SDF_TIMED; // Retrigger restarts hold
        end else if (expire) begin
          nxt_state = SDF_OFF;
        end
      end
      SDF_LATCH: begin
        if (press) begin
          nxt_state = SDF_OFF;
        end
      end
      default: nxt_state = SDF_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SDF_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Hold timer reloads on each press while timed, so people on the stairs extend it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_ff <= '0;
    end else if (press && !pulse_mode && state_ff != SDF_LATCH) begin
      tmr_ff <= hold_ff;
    end else if (tick && tmr_ff != '0 && (state_ff == SDF_TIMED || state_ff == SDF_WARN)) begin
      tmr_ff <= tmr_ff - TW'(1);
    end
  end

  // Flicker toggles the lamp off briefly at a fixed rate during warning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flick_cnt_ff <= '0;
      flick_ff <= 1'b0;
    end else if (state_ff != SDF_WARN) begin
      flick_cnt_ff <= '0;
      flick_ff <= 1'b0;
    end else if (tick) begin
      if (flick_cnt_ff >= TW'(FLICK_TICKS - 1)) begin
        flick_cnt_ff <= '0;
        flick_ff <= ~flick_ff;
      end else begin
        flick_cnt_ff <= flick_cnt_ff + TW'(1);
      end
    end
  end

  // Overrides act on the lamp only; state machine and timer keep running underneath
  // Central-on wins over central-off: emergency light must not be blocked
  always_comb begin
    nxt_lamp = (nxt_state != SDF_OFF);
    if (nxt_state == SDF_WARN && flick_ff) begin
      nxt_lamp = 1'b0;
    end
    if (ctrl_ff.coff_en && coff) begin
      nxt_lamp = 1'b0;
    end
    if (ctrl_ff.con_en && con) begin
      nxt_lamp = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_ff <= 1'b0;
    end else begin
      lamp_ff <= nxt_lamp;
    end
  end
  assign lamp_output = lamp_ff;

endmodule

// *** bench/sdf_switch_props.sv ***
// Port checker for the stairway lamp switch.
// Assumes pready is tied high and a CTRL write lands at the access edge.
module sdf_switch_props
  import sdf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic light_button_input,
  input wire logic central_off_input,
  input wire logic central_on_input,
  input wire logic lamp_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] ctrl_ff;
  // Shadow of CTRL, so mode-dependent checks know the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
      ctrl_ff <= pwdata[4:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  a_pulse_toggle: assert property ($rose(light_button_input) && ctrl_ff[1:0] == 2'h0 &&
    !central_on_input && !central_off_input |-> ##[3:9] $changed(lamp_output)) else $error("no toggle");
  a_pulse_quiet: assert property ((ctrl_ff[1:0] == 2'h0 && !light_button_input &&
    !central_on_input && !central_off_input)[*8] |-> $stable(lamp_output)) else $error("lamp moved");
  a_timed_on: assert property ($rose(light_button_input) && ctrl_ff[1:0] != 2'h0 &&
    !lamp_output && !central_off_input |-> ##[3:9] lamp_output) else $error("timed lamp not on");
  a_central_on: assert property ((ctrl_ff[4] && central_on_input)[*8] |-> lamp_output)
    else $error("central on ignored");
  a_central_off: assert property ((ctrl_ff[3] && central_off_input && !central_on_input)[*8]
    |-> !lamp_output) else $error("central off ignored");
  a_stat_lamp: assert property (psel && penable && !pwrite && paddr == ADDR_STAT
    |-> prdata[0] == $past(lamp_output) && $onehot(prdata[7:4])) else $error("status wrong");
  a_err_unmapped: assert property (psel && penable && paddr > ADDR_STAT |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access accepted");
  a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  cover property ($rose(lamp_output));
  cover property (central_on_input && lamp_output);
  cover property (pslverr);
endmodule

bind sdf_switch sdf_switch_props props_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .light_button_input, .central_off_input, .central_on_input, .lamp_output);

// *** bench/sdf_button_lamp.sv ***
// Pushbutton and lamp load model for the lamp switch bench.
// Assumes press is called from one process at a time.
module sdf_button_lamp (
  // Clock
  input wire logic pclk,
  // Pins
  input wire logic lamp_output,
  output logic light_button_input,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lamp_q;
  initial begin
    light_button_input = 1'b0;
    rises = 0;
    lamp_q = 1'b0;
  end
  // Load counts switch-on events, so a flicker shows as extra rises
  always @(posedge pclk) begin
    if (lamp_output === 1'b1 && lamp_q === 1'b0) begin
      rises <= rises + 1;
    end
    lamp_q <= lamp_output;
  end
  task press(input int hi);
    @(posedge pclk);
    light_button_input <= 1'b1;
    repeat (hi) @(posedge pclk);
    light_button_input <= 1'b0;
    // Contacts stay open long enough to read as a fresh press
    repeat (4) @(posedge pclk);
  endtask
endmodule

// *** bench/sdf_switch_tb_top.sv ***
// Self-checking bench for the stairway lamp switch.
// Assumes a 4-cycle tick so hold and long-press times stay short.
module sdf_switch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, con, coff;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, btn, lamp;
  int rises, err_count = 0, total_checks = 0;
  sdf_switch #(.TICK_DIV(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .light_button_input(btn), .central_off_input(coff), .central_on_input(con),
    .lamp_output(lamp));
  sdf_button_lamp load_u (.pclk, .lamp_output(lamp), .light_button_input(btn), .rises);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      $display("unexpected %s exp %h got %h", n, x, g);
      err_count++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(0, a, 0, r, e);
    chk("prdata", x, r);
    chk("pslverr", xe, e);
  endtask
  task lamp_is(input int n, input logic x);
    repeat (n) @(posedge pclk);
    // Look mid-cycle, where the registered lamp has settled
    @(negedge pclk);
    chk("lamp", x, lamp);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(ADDR_CTRL, 32'(CTRL_RESET), 0);
    rd(ADDR_HOLD, 32'(HOLD_TICKS), 0);
    rd(ADDR_LONG, 32'(LONG_TICKS), 0);
    rd(8'h10, 32'h0, 1);
    wr(ADDR_STAT, 32'hffffffff);
    rd(ADDR_STAT, 32'h10, 0); // Read-only status: off state, lamp low
  endtask
  task t_pulse;
    wr(ADDR_CTRL, 32'h0);
    load_u.press(2); lamp_is(4, 1);
    load_u.press(60); lamp_is(4, 0);
  endtask
  task t_timed;
    wr(ADDR_HOLD, 32'd20);
    for (int m = 1; m < 3; m++) begin
      wr(ADDR_CTRL, 32'(m));
      load_u.press(2); lamp_is(4, 1);
      lamp_is(50, 1);
      lamp_is(40, 0);
    end
  endtask
  task t_latch;
    wr(ADDR_LONG, 32'd10);
    load_u.press(60); lamp_is(150, 1);
    load_u.press(2); lamp_is(4, 0);
    lamp_is(100, 0);
  endtask
  task t_warn;
    int r0;
    wr(ADDR_CTRL, 32'h6);
    wr(ADDR_HOLD, 32'd400);
    r0 = rises;
    load_u.press(2); lamp_is(1800, 0);
    chk("flicker", 1, 32'(rises - r0 > 2));
  endtask
  task t_central;
    wr(ADDR_CTRL, 32'h18);
    con <= 1; lamp_is(10, 1);
    coff <= 1; lamp_is(10, 1);
    con <= 0; lamp_is(10, 0);
    load_u.press(2); lamp_is(4, 0);
    coff <= 0;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    complete_run();
  end
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    con <= 1'b0;
    coff <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_regs(); t_pulse(); t_timed(); t_latch(); t_warn(); t_central();
    complete_run();
  end
endmodule
